// *** src/scp_pkg.sv ***
// Package for the supply configuration and pulse output register group
package scp_pkg;
  // ==========================================================
  // Register offsets (7-bit frame addresses)
  localparam logic [6:0] ADDR_REG_CLK_LOCK = 7'h0F;
  localparam logic [6:0] ADDR_PIN_CFG = 7'h17;
  localparam logic [6:0] ADDR_DUTY = 7'h18;
  localparam logic [6:0] ADDR_RATE = 7'h1C;
  localparam logic [6:0] ADDR_PROT = 7'h1D;
  // ==========================================================
  // Power-on values
  localparam logic [7:0] POR_REG_CLK_LOCK = 8'h40;
  localparam logic [7:0] POR_PIN_CFG = 8'h00;
  localparam logic [7:0] POR_DUTY = 8'h00;
  localparam logic [7:0] POR_RATE = 8'h00;
  localparam logic [7:0] POR_PROT = 8'h01;
  // ==========================================================
  // Field positions and writable masks
  localparam int SW_FREQ_LSB = 5;
  localparam int PEAK_TH_BIT = 4;
  localparam int SPREAD_LSB = 2;
  localparam int LOCK1_BIT = 0;
  localparam logic [7:0] MASK_REG_CLK_LOCK = 8'hFD;
  localparam logic [7:0] MASK_PIN_CFG = 8'h07;
  localparam logic [7:0] MASK_RATE = 8'h03;
  localparam logic [7:0] MASK_PROT = 8'h07;
  // ==========================================================
  // Pin modes
  typedef enum logic [2:0] {
    PIN_FAIL0 = 3'h0,
    PIN_FAIL1 = 3'h1,
    PIN_FAIL2 = 3'h2,
    PIN_HS_TIMER = 3'h3,
    PIN_OFF = 3'h4,
    PIN_WAKE = 3'h5,
    PIN_LS_PWM = 3'h6,
    PIN_HS_PWM = 3'h7
  } scp_pin_mode_t;
  // ==========================================================
  // Timing at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int WAKE_FILTER_US = 16;
  localparam int WAKE_FILTER_CYC = (WAKE_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWM_HZ_0 = 100;
  localparam int PWM_HZ_1 = 200;
  localparam int PWM_HZ_2 = 325;
  localparam int PWM_HZ_3 = 400;
  localparam int PWM_STEPS = 255;
  // ==========================================================
  // Register access frame
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } scp_req_t;
  // Decoded analog settings
  typedef struct packed {
    logic [2:0] switching_freq_sel;
    logic peak_threshold_sel;
    logic [1:0] spread_mod_rate;
    logic thermal_trip_sel;
    logic [1:0] supply_current_limit_adj;
  } scp_analog_t;
endpackage

// *** src/scp_regs.sv ***
// Supply configuration, lock and pulse output register group
`timescale 1ns/1ps
`default_nettype none
module scp_regs (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic soft_reset_in,
  input wire logic restart_in,
  input wire logic cs_n_in,
  input wire scp_pkg::scp_req_t req_in,
  input wire logic lock0_in,
  input wire logic fail_safe_in,
  input wire logic pin_level_in,
  output logic [7:0] rdata_out,
  output scp_pkg::scp_analog_t analog_out,
  output logic [2:0] pin_mode_out,
  output logic fail_output_out,
  output logic timer_hs_out,
  output logic pwm_on_out,
  output logic wake_event_out,
  output logic wake_source_out
);
  import scp_pkg::*;

  // ==========================================================
  // Register state
  // Lock bits sit apart from the stored byte so activation can lag the write
  logic [7:0] clk_lock_q, clk_lock_d;
  logic [2:0] pin_q, pin_d;
  logic [7:0] duty_q, duty_d;
  logic [1:0] rate_q, rate_d;
  logic [2:0] prot_q, prot_d;
  logic lock1_arm_q, lock1_arm_d;
  logic lock1_act_q, lock1_act_d;
  logic cs_n_q;
  logic [7:0] rdata_d;

  // Restart value of the pin mode, keyed by the mode in force.
  // Wake and off are harmless through a restart; any switch or timer
  // mode drops back to fail output so no load is driven unattended.
  function automatic logic [2:0] pin_restart(input logic [2:0] m);
    case (m)
      PIN_WAKE, PIN_OFF: pin_restart = m;
      default: pin_restart = PIN_FAIL0;
    endcase
  endfunction

  // ==========================================================
  // Register write path and resets
  // Priority is soft reset, then restart, then a bus write; a write in
  // the same cycle as either reset is lost on purpose.
  // Reserved and locked bits are masked here so reads need no extra state.
  always_comb begin
    clk_lock_d = clk_lock_q;
    pin_d = pin_q;
    duty_d = duty_q;
    rate_d = rate_q;
    prot_d = prot_q;
    lock1_arm_d = lock1_arm_q;
    lock1_act_d = lock1_act_q;
    if (soft_reset_in) begin
      // Lock state kept through soft reset
      if (!lock1_act_q) begin
        clk_lock_d = POR_REG_CLK_LOCK | {7'h00, clk_lock_q[LOCK1_BIT]};
        prot_d = POR_PROT[2:0];
      end
      if (!lock0_in) begin
        pin_d = pin_restart(pin_q);
      end
      duty_d = POR_DUTY;
      rate_d = POR_RATE[1:0];
    end else if (restart_in) begin
      // Restart keeps configuration; pin mode follows its own restart
      pin_d = pin_restart(pin_q);
    end else if (req_in.wr) begin
      if (req_in.addr == ADDR_REG_CLK_LOCK) begin
        if (!lock1_act_q) begin
          clk_lock_d = req_in.wdata & MASK_REG_CLK_LOCK;
          lock1_arm_d = req_in.wdata[LOCK1_BIT];
        end
      end else if (req_in.addr == ADDR_PIN_CFG) begin
        if (!lock0_in) begin
          pin_d = req_in.wdata[2:0];
        end
      end else if (req_in.addr == ADDR_DUTY) begin
        duty_d = req_in.wdata;
      end else if (req_in.addr == ADDR_RATE) begin
        rate_d = req_in.wdata[1:0];
      end else if (req_in.addr == ADDR_PROT) begin
        if (!lock1_act_q) begin
          prot_d = req_in.wdata[2:0];
        end
      end
    end
    // Lock armed by the write becomes active on chip select rising.
    // Arming apart from activation lets the same frame still finish
    // its remaining writes before the lockable bits freeze.
    if (lock1_arm_q && cs_n_in && !cs_n_q) begin
      lock1_act_d = 1'b1;
    end
  end

  // ==========================================================
  // Read mux, reserved bits zero
  // Data is registered, so it stands one cycle after the read strobe
  // and returns to zero otherwise, keeping the bus quiet between reads.
  always_comb begin
    rdata_d = 8'h00;
    if (req_in.rd) begin
      if (req_in.addr == ADDR_REG_CLK_LOCK) begin
        rdata_d = clk_lock_q & MASK_REG_CLK_LOCK;
      end else if (req_in.addr == ADDR_PIN_CFG) begin
        rdata_d = {5'h00, pin_q};
      end else if (req_in.addr == ADDR_DUTY) begin
        rdata_d = duty_q;
      end else if (req_in.addr == ADDR_RATE) begin
        rdata_d = {6'h00, rate_q};
      end else if (req_in.addr == ADDR_PROT) begin
        rdata_d = {5'h00, prot_q};
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  // ==========================================================
  // Power-on reset is the only path that clears the lock
  // Soft reset and restart act through the next-state logic instead,
  // so soft reset can honour the locks that power-on reset must override.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_lock_q <= POR_REG_CLK_LOCK;
      pin_q <= POR_PIN_CFG[2:0];
      duty_q <= POR_DUTY;
      rate_q <= POR_RATE[1:0];
      prot_q <= POR_PROT[2:0];
      lock1_arm_q <= 1'b0;
      lock1_act_q <= 1'b0;
      cs_n_q <= 1'b1;
      rdata_out <= 8'h00;
    end else begin
      clk_lock_q <= clk_lock_d;
      pin_q <= pin_d;
      duty_q <= duty_d;
      rate_q <= rate_d;
      prot_q <= prot_d;
      lock1_arm_q <= lock1_arm_d;
      lock1_act_q <= lock1_act_d;
      cs_n_q <= cs_n_in;
      rdata_out <= rdata_d;
    end
  end

  // ==========================================================
  // PWM engine: period length chosen per rate code
  // Slot lengths are whole clocks, so the real rate sits slightly above
  // the nominal one; the truncation error stays below one percent.
  // A rate change waits for the period end, like the duty.
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam logic [16:0] STEP_0 = 17'((CLK_HZ / PWM_HZ_0) / PWM_STEPS);
  localparam logic [16:0] STEP_1 = 17'((CLK_HZ / PWM_HZ_1) / PWM_STEPS);
  localparam logic [16:0] STEP_2 = 17'((CLK_HZ / PWM_HZ_2) / PWM_STEPS);
  localparam logic [16:0] STEP_3 = 17'((CLK_HZ / PWM_HZ_3) / PWM_STEPS);

  // Clocks per slot for each rate code
  function automatic logic [16:0] step_len(input logic [1:0] r);
    case (r)
      2'h0: step_len = STEP_0;
      2'h1: step_len = STEP_1;
      2'h2: step_len = STEP_2;
      default: step_len = STEP_3;
    endcase
  endfunction

  // True in either switch mode driven by the pulse engine;
  // used both to park the engine and to gate its output
  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = (m == PIN_LS_PWM) || (m == PIN_HS_PWM);
  endfunction

  // Prescaler, slot counter and the settings in force for this period
  logic [16:0] pre_q, pre_d;
  logic [7:0] slot_q, slot_d;
  logic [7:0] act_duty_q, act_duty_d;
  logic [1:0] act_rate_q, act_rate_d;
  logic pwm_on_d;

  // Settings latched at period boundary or while parked, avoiding runt pulses
  always_comb begin
    pre_d = pre_q + 17'h00001;
    slot_d = slot_q;
    act_duty_d = act_duty_q;
    act_rate_d = act_rate_q;
    if (!is_pwm(pin_q)) begin
      // Parked at period start while unused and tracking the registers,
      // so the first period after the mode switch already runs the new duty
      pre_d = 17'h00000;
      slot_d = 8'h00;
      act_duty_d = duty_q;
      act_rate_d = rate_q;
    end else if (pre_q >= step_len(act_rate_q) - 17'h00001) begin
      pre_d = 17'h00000;
      if (slot_q >= 8'(PWM_STEPS - 1)) begin
        slot_d = 8'h00;
        act_duty_d = duty_q;
        act_rate_d = rate_q;
      end else begin
        slot_d = slot_q + 8'h01;
      end
    end
    // Duty 0 never beats slot 0; duty 255 covers all 255 slots
    pwm_on_d = is_pwm(pin_q) && (slot_q < act_duty_q);
  end

  // Pulse engine registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_q <= 17'h00000;
      slot_q <= 8'h00;
      act_duty_q <= 8'h00;
      act_rate_q <= 2'h0;
      pwm_on_out <= 1'b0;
    end else begin
      pre_q <= pre_d;
      slot_q <= slot_d;
      act_duty_q <= act_duty_d;
      act_rate_q <= act_rate_d;
      pwm_on_out <= pwm_on_d;
    end
  end

  // ==========================================================
  // Wake filter and pin function decode
  // The filter restarts on any bounce, so a level must stand the full
  // window unbroken; outside wake mode it stays cleared and silent.
  // Filter count and the last accepted level
  logic [7:0] wf_cnt_q, wf_cnt_d;
  logic wf_lvl_q, wf_lvl_d;
  logic wake_d;

  // Count cycles of a differing level before accepting it
  always_comb begin
    wf_cnt_d = wf_cnt_q;
    wf_lvl_d = wf_lvl_q;
    wake_d = 1'b0;
    if (pin_q != PIN_WAKE || pin_level_in == wf_lvl_q) begin
      wf_cnt_d = 8'h00;
    end else if (wf_cnt_q >= 8'(WAKE_FILTER_CYC - 1)) begin
      wf_cnt_d = 8'h00;
      wf_lvl_d = pin_level_in;
      wake_d = 1'b1;
    end else begin
      wf_cnt_d = wf_cnt_q + 8'h01;
    end
  end

  // Filter state and registered pin outputs
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wf_cnt_q <= 8'h00;
      wf_lvl_q <= 1'b0;
      wake_event_out <= 1'b0;
      wake_source_out <= 1'b0;
      pin_mode_out <= 3'h0;
      fail_output_out <= 1'b1; // Power-on pin mode is fail output
      timer_hs_out <= 1'b0;
      analog_out <= '0;
    end else begin
      wf_cnt_q <= wf_cnt_d;
      wf_lvl_q <= wf_lvl_d;
      wake_event_out <= wake_d;
      wake_source_out <= fail_safe_in && (pin_q == PIN_WAKE);
      pin_mode_out <= pin_q;
      fail_output_out <= (pin_q <= PIN_FAIL2);
      timer_hs_out <= (pin_q == PIN_HS_TIMER);
      analog_out <= {clk_lock_q[7:5], clk_lock_q[PEAK_TH_BIT], clk_lock_q[3:2],
                     prot_q};
    end
  end
endmodule
`default_nettype wire

// *** test/scp_host.sv ***
// Host model that issues single-byte register frames
`timescale 1ns/1ps
`default_nettype none
module scp_host (
  input wire logic mclk_in,
  input wire logic [7:0] rdata_in,
  output logic cs_n_out,
  output scp_pkg::scp_req_t req_out
);
  import scp_pkg::*;
  // ==========================================
  // Idle: deselected, no request
  initial begin
    cs_n_out = 1'b1;
    req_out = '0;
  end
  // Chip select level, moved off the sampling edge
  task automatic sel(input logic v);
    @(negedge mclk_in);
    cs_n_out = v;
  endtask
  // Held one full cycle; released fields show inverted garbage
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge mclk_in);
    req_out = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge mclk_in);
    q = rdata_in;
    req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// *** test/scp_regs_sva.sv ***
// Port checker for the register group
`timescale 1ns/1ps
`default_nettype none
module scp_regs_chk (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic soft_reset_in,
  input wire logic restart_in,
  input wire logic lock0_in,
  input wire logic fail_safe_in,
  input wire logic pin_level_in,
  input wire scp_pkg::scp_req_t req_in,
  input wire logic [7:0] rdata_out,
  input wire logic [2:0] pin_mode_out,
  input wire logic fail_output_out,
  input wire logic timer_hs_out,
  input wire logic wake_event_out,
  input wire logic wake_source_out
);
  import scp_pkg::*;
  logic [7:0] stab_q;
  logic [7:0] stab_d;
  logic lvl_q;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================
  // Cycles the pin level held; saturates so long idle stays legal
  always_comb begin
    stab_d = stab_q;
    if (pin_level_in != lvl_q) stab_d = 8'h00;
    else if (stab_q != 8'hFF) stab_d = stab_q + 8'h01;
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stab_q <= 8'h00;
      lvl_q <= 1'b0;
    end else begin
      stab_q <= stab_d;
      lvl_q <= pin_level_in;
    end
  end
  // Output decode and read path
  a_fail_decode: assert property (fail_output_out == (pin_mode_out <= 3'h2))
    else $error("fail output decode");
  a_timer_decode: assert property (timer_hs_out == (pin_mode_out == 3'h3))
    else $error("timer switch decode");
  a_rdata_idle: assert property (!$past(req_in.rd) |-> rdata_out == 8'h00)
    else $error("read data not idle");
  a_rate_reserved: assert property (
    $past(req_in.rd) && $past(req_in.addr) == ADDR_RATE |-> rdata_out[7:2] == 6'h00)
    else $error("rate reserved bits set");
  a_wake_source: assert property (
    wake_source_out == ($past(fail_safe_in) && pin_mode_out == PIN_WAKE))
    else $error("wake source mismatch");
  a_wake_filter: assert property (wake_event_out |-> stab_q >= WAKE_FILTER_CYC - 4)
    else $error("wake event too early");
  a_pin_kept: assert property (
    (restart_in || soft_reset_in) ##1 pin_mode_out inside {PIN_OFF, PIN_WAKE}
    |=> $stable(pin_mode_out))
    else $error("pin mode not kept");
  a_pin_cleared: assert property (
    restart_in ##1 !(pin_mode_out inside {PIN_OFF, PIN_WAKE}) |=> pin_mode_out == 3'h0)
    else $error("pin mode not cleared");
  a_lock0_hold: assert property (
    lock0_in && !restart_in && !soft_reset_in |-> ##2 $stable(pin_mode_out))
    else $error("pin mode changed under lock");
endmodule
bind scp_regs scp_regs_chk u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .soft_reset_in(soft_reset_in), .restart_in(restart_in), .lock0_in(lock0_in),
  .fail_safe_in(fail_safe_in), .pin_level_in(pin_level_in), .req_in(req_in),
  .rdata_out(rdata_out), .pin_mode_out(pin_mode_out), .fail_output_out(fail_output_out),
  .timer_hs_out(timer_hs_out), .wake_event_out(wake_event_out),
  .wake_source_out(wake_source_out));
`default_nettype wire

// *** test/test_scp_regs.sv ***
// Directed bench for the register group
`timescale 1ns/1ps
`default_nettype none
module test_scp_regs;
  import scp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic srst = 1'b0;
  logic rstrt = 1'b0;
  logic lock0 = 1'b0;
  logic fsafe = 1'b0;
  logic lvl = 1'b0;
  logic cs_n;
  scp_req_t req;
  logic [7:0] rdata;
  scp_analog_t ana;
  logic [2:0] mode;
  logic fo, tho, pwm, wev, wsrc;
  int err_count = 0;
  int samples_checked = 0;
  int n;
  logic [7:0] q;
  logic [6:0] ad [5] = '{ADDR_REG_CLK_LOCK, ADDR_PIN_CFG, ADDR_DUTY, ADDR_RATE, ADDR_PROT};
  logic [7:0] por [5] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h01};
  logic [7:0] msk [5] = '{MASK_REG_CLK_LOCK, MASK_PIN_CFG, 8'hFF, MASK_RATE, MASK_PROT};
  // 10 MHz clock
  initial forever #50 clk = ~clk;
  scp_host host (.mclk_in(clk), .rdata_in(rdata), .cs_n_out(cs_n), .req_out(req));
  scp_regs uut (.mclk_in(clk), .rst_n_in(rst_n), .soft_reset_in(srst), .restart_in(rstrt),
    .cs_n_in(cs_n), .req_in(req), .lock0_in(lock0), .fail_safe_in(fsafe),
    .pin_level_in(lvl), .rdata_out(rdata), .analog_out(ana), .pin_mode_out(mode),
    .fail_output_out(fo), .timer_hs_out(tho), .pwm_on_out(pwm), .wake_event_out(wev),
    .wake_source_out(wsrc));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_ana(input scp_analog_t got, input scp_analog_t exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: analog got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  // One-cycle soft reset or restart pulse
  task automatic kick(input logic s);
    @(negedge clk);
    if (s) srst = 1'b1;
    else rstrt = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    rstrt = 1'b0;
  endtask
  // Watchdog: a hung wait counts as a mismatch; about three times the run
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    host.sel(1'b0);
    for (int i = 0; i < 5; i++) rc(ad[i], por[i]);
    chk_ana(ana, 9'h081);
    // Duty first, then rate, then the PWM mode; duty is rewritten mid-period
    wr(ADDR_DUTY, 8'h80);
    wr(ADDR_RATE, 8'h03);
    wr(ADDR_PIN_CFG, 8'h07);
    n = 0;
    while (pwm !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (pwm === 1'b1 && n < 30000) begin
      @(negedge clk);
      n++;
      if (n == 100) begin
        wr(ADDR_DUTY, 8'hFF);
        n += 2;
      end
    end
    chk(8'(n > 12416 && n < 12672), 8'h01);
    for (int i = 0; i < 5; i++) wr(ad[i], 8'hFE);
    for (int i = 0; i < 5; i++) rc(ad[i], 8'hFE & msk[i]);
    chk_ana(ana, 9'h1FE);
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_PIN_CFG, 8'(m));
      @(negedge clk);
      chk(8'({mode, fo, tho}), 8'({3'(m), m <= 2, m == 3}));
    end
    lock0 = 1'b1;
    wr(ADDR_PIN_CFG, 8'h04);
    rc(ADDR_PIN_CFG, 8'h07);
    lock0 = 1'b0;
    wr(ADDR_PIN_CFG, 8'h05);
    rc(ADDR_PIN_CFG, 8'h05);
    fsafe = 1'b1;
    repeat (3) @(negedge clk);
    chk(8'(wsrc), 8'h01);
    lvl = 1'b1;
    n = 0;
    while (wev !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n >= WAKE_FILTER_CYC - 2 && n <= WAKE_FILTER_CYC + 3), 8'h01);
    kick(1'b1);
    rc(ADDR_PIN_CFG, 8'h05);
    rc(ADDR_PROT, 8'h01);
    wr(ADDR_PIN_CFG, 8'h07);
    kick(1'b0);
    rc(ADDR_PIN_CFG, 8'h00);
    // Lock armed in a frame, still open until chip select rises
    wr(ADDR_PROT, 8'h06);
    wr(ADDR_REG_CLK_LOCK, 8'h01);
    wr(ADDR_REG_CLK_LOCK, 8'h21);
    rc(ADDR_REG_CLK_LOCK, 8'h21);
    host.sel(1'b1);
    host.sel(1'b0);
    wr(ADDR_REG_CLK_LOCK, 8'h40);
    rc(ADDR_REG_CLK_LOCK, 8'h21);
    wr(ADDR_PROT, 8'h04);
    rc(ADDR_PROT, 8'h06);
    wr(ADDR_DUTY, 8'h33);
    rc(ADDR_DUTY, 8'h33);
    kick(1'b1);
    rc(ADDR_REG_CLK_LOCK, 8'h21);
    rc(ADDR_PROT, 8'h06);
    rc(ADDR_DUTY, 8'h00);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rc(ADDR_REG_CLK_LOCK, 8'h40);
    give_verdict();
  end
endmodule
`default_nettype wire
